// *** include/udis_pkg.sv ***
/*
  Shared constants of the device-mode interrupt status block: register
  indices, bit positions, masks, reset values, bulk wrapper lengths and the
  bus inactivity timing. Assumes a 250 MHz system clock and a 32-bit
  AXI4-Lite register bus with byte address equal to four times the index.
*/
package udis_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned IDX_W = 10;
  localparam int unsigned NUM_EP = 5;
  localparam int unsigned EP_STAT_W = 8;
  localparam int unsigned ALARM_W = 16;
  localparam int unsigned ADDR_FIELD_W = 7;
  localparam int unsigned LEN_W = 10;

  localparam logic [IDX_W-1:0] BUS_EVENT_IDX = 10'h0b0;
  localparam logic [IDX_W-1:0] BULK_WRAPPER_IDX = 10'h0b3;
  localparam logic [IDX_W-1:0] EP_SUMMARY_IDX = 10'h0b4;
  localparam logic [IDX_W-1:0] CONTROL_IDX = 10'h0c0;
  localparam logic [IDX_W-1:0] STATUS_IDX = 10'h0c1;

  localparam int unsigned BEV_NON_IDLE = 6;
  localparam int unsigned BEV_FRAME_START = 5;
  localparam int unsigned BEV_BUS_RESET = 4;
  localparam int unsigned BEV_SUSPEND = 3;
  localparam int unsigned BEV_HANDSHAKE = 2;
  localparam int unsigned BEV_RESTORE = 1;
  localparam int unsigned BEV_ADDRESS = 0;
  localparam logic [7:0] BEV_MASK = 8'h7f;
  localparam logic [7:0] BEV_HOST_MASK = 8'h40;
  localparam logic [7:0] BEV_RESET_VAL = 8'h00;

  localparam int unsigned BULK_CMD_DONE = 7;
  localparam int unsigned BULK_CMD_LEN_ERR = 6;
  localparam int unsigned BULK_CMD_ERR = 5;
  localparam int unsigned BULK_STS_DONE = 3;
  localparam int unsigned BULK_STS_ERR = 2;
  localparam logic [7:0] BULK_MASK = 8'hec;
  localparam logic [7:0] BULK_RESET_VAL = 8'h00;

  localparam int unsigned SUM_ALARM_IN = 7;
  localparam int unsigned SUM_ALARM_OUT = 6;
  localparam logic [7:0] SUM_RESET_VAL = 8'h00;

  localparam int unsigned CTL_HOST_SEL = 0;
  localparam int unsigned CTL_ACTIVATE = 1;
  localparam int unsigned CTL_AUTO_NEGO = 2;
  localparam int unsigned CTL_DETECT_DIS = 3;
  localparam int unsigned CTL_AUTO_ADDR = 4;
  localparam int unsigned CTL_CHIRP_GO = 5;
  localparam int unsigned CTL_RESTORE_GO = 6;
  localparam int unsigned CTL_STORED_W = 5;
  localparam logic [CTL_STORED_W-1:0] CTL_RESET_VAL = 5'h00;

  localparam int unsigned STS_SPEED_FS = 0;
  localparam int unsigned STS_FS_TERM = 1;
  localparam int unsigned STS_HS_BUSY = 2;
  localparam int unsigned STS_RESTORE_BUSY = 3;
  localparam int unsigned STS_ADDR_LSB = 8;

  localparam logic [LEN_W-1:0] CMD_WRAPPER_LEN = 10'h01f;
  localparam logic [LEN_W-1:0] STS_WRAPPER_LEN = 10'h00d;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned INACT_TIME_NS = 3000;
  localparam int unsigned INACT_CYCLES = (INACT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned INACT_CNT_W = 10;
  localparam logic [INACT_CNT_W-1:0] INACT_LAST = INACT_CNT_W'(INACT_CYCLES - 1);
endpackage

// *** design/udis_top.sv ***
/*
  Device-mode interrupt status block: bus-event flags, bulk wrapper flags,
  the endpoint/alarm summary, the speed and termination state, and an
  AXI4-Lite slave for its registers. Assumes the serial engine delivers
  its events as one-cycle pulses on aclk, and that the line state bits come
  from the transceiver pins asynchronously.
*/
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns

module udis_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [udis_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [udis_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic line_j_pin,
  input wire logic line_se0_pin,
  input wire logic snooze_indicator,
  input wire logic suspend_indicator,
  input wire logic bus_activity,
  input wire logic frame_start_seen,
  input wire logic suspend_seen,
  input wire logic chirp_end,
  input wire logic chirp_hs,
  input wire logic restore_end,
  input wire logic setaddr_status_done,
  input wire logic [udis_pkg::ADDR_FIELD_W-1:0] setaddr_value,
  input wire logic cmd_wrapper_rx,
  input wire logic [udis_pkg::LEN_W-1:0] cmd_wrapper_len,
  input wire logic cmd_wrapper_bad,
  input wire logic sts_wrapper_tx,
  input wire logic [udis_pkg::LEN_W-1:0] sts_wrapper_len,
  input wire logic sts_wrapper_no_ack,
  input wire logic [udis_pkg::NUM_EP*udis_pkg::EP_STAT_W-1:0] ep_stat,
  input wire logic [udis_pkg::NUM_EP*udis_pkg::EP_STAT_W-1:0] ep_enb,
  input wire logic [udis_pkg::ALARM_W-1:0] alarm_in_stat,
  input wire logic [udis_pkg::ALARM_W-1:0] alarm_in_enb,
  input wire logic [udis_pkg::ALARM_W-1:0] alarm_out_stat,
  input wire logic [udis_pkg::ALARM_W-1:0] alarm_out_enb,
  output logic hs_mode,
  output logic fs_termination,
  output logic chirp_go,
  output logic restore_go,
  output logic [udis_pkg::ADDR_FIELD_W-1:0] device_address
);
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_held_r, w_held_r;
  logic [udis_pkg::ADDR_W-1:0] aw_addr_r;
  logic [7:0] wdata_r;
  logic wstrb0_r;
  logic [1:0] sync1_r, sync2_r;
  logic [7:0] bus_event_status_reg, bulk_wrapper_status_reg, endpoint_summary_status_reg;
  logic [udis_pkg::CTL_STORED_W-1:0] ctrl_r;
  logic hs_mode_r, saved_hs_r, fs_term_r, chirp_go_r, restore_go_r, chirp_busy_r, restore_busy_r;
  logic [udis_pkg::ADDR_FIELD_W-1:0] dev_addr_r;
  logic [udis_pkg::INACT_CNT_W-1:0] inact_cnt_r;
  logic wr_fire, wr_hit, wr_low, dev_mode, line_j_s, line_se0_s, inact_done;
  logic reset_evt, suspend_evt, non_idle_enable;
  logic [udis_pkg::IDX_W-1:0] wr_idx, rd_idx;
  logic [7:0] bev_set, bev_clr, bulk_set, bulk_clr, bev_rd_mask;
  logic [31:0] rd_data_nxt;
  logic rd_hit_nxt;
  logic [udis_pkg::NUM_EP-1:0] ep_any;

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign hs_mode = hs_mode_r;
  assign fs_termination = fs_term_r;
  assign chirp_go = chirp_go_r;
  assign restore_go = restore_go_r;
  assign device_address = dev_addr_r;

  assign dev_mode = ~ctrl_r[udis_pkg::CTL_HOST_SEL];
  assign line_j_s = sync2_r[0];
  assign line_se0_s = sync2_r[1];
  assign wr_idx = aw_addr_r[udis_pkg::ADDR_W-1:2];
  assign rd_idx = araddr[udis_pkg::ADDR_W-1:2];
  assign wr_fire = aw_held_r & w_held_r & ~bvalid_r;
  assign wr_low = wr_fire & wstrb0_r;
  assign bev_rd_mask = dev_mode ? udis_pkg::BEV_MASK : udis_pkg::BEV_HOST_MASK;

  // The line state pins are asynchronous; only the second stage is read.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {line_se0_pin, line_j_pin};
      sync2_r <= sync1_r;
    end
  end

  // Write address and data are taken independently and held until the response is accepted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (awvalid && awready_r) begin
      awready_r <= 1'b0;
      aw_held_r <= 1'b1;
      aw_addr_r <= awaddr;
    end else if (bvalid_r && bready) begin
      aw_held_r <= 1'b0;
      awready_r <= 1'b1;
    end else if (!aw_held_r && !bvalid_r) begin
      awready_r <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b0;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (wvalid && wready_r) begin
      wready_r <= 1'b0;
      w_held_r <= 1'b1;
      wdata_r <= wdata[7:0];
      wstrb0_r <= wstrb[0];
    end else if (bvalid_r && bready) begin
      w_held_r <= 1'b0;
      wready_r <= 1'b1;
    end else if (!w_held_r && !bvalid_r) begin
      wready_r <= 1'b1;
    end
  end

  always_comb begin
    case (wr_idx)
      udis_pkg::BUS_EVENT_IDX, udis_pkg::BULK_WRAPPER_IDX, udis_pkg::EP_SUMMARY_IDX,
      udis_pkg::CONTROL_IDX, udis_pkg::STATUS_IDX: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= udis_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? udis_pkg::RESP_OKAY : udis_pkg::RESP_DECERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_comb begin
    rd_data_nxt = 32'h0000_0000;
    rd_hit_nxt = 1'b1;
    case (rd_idx)
      udis_pkg::BUS_EVENT_IDX: rd_data_nxt[7:0] = bus_event_status_reg & bev_rd_mask;
      udis_pkg::BULK_WRAPPER_IDX: rd_data_nxt[7:0] = bulk_wrapper_status_reg;
      udis_pkg::EP_SUMMARY_IDX: rd_data_nxt[7:0] = endpoint_summary_status_reg;
      udis_pkg::CONTROL_IDX: rd_data_nxt[udis_pkg::CTL_STORED_W-1:0] = ctrl_r;
      udis_pkg::STATUS_IDX: begin
        rd_data_nxt[udis_pkg::STS_SPEED_FS] = ~hs_mode_r;
        rd_data_nxt[udis_pkg::STS_FS_TERM] = fs_term_r;
        rd_data_nxt[udis_pkg::STS_HS_BUSY] = chirp_busy_r;
        rd_data_nxt[udis_pkg::STS_RESTORE_BUSY] = restore_busy_r;
        rd_data_nxt[udis_pkg::STS_ADDR_LSB +: udis_pkg::ADDR_FIELD_W] = dev_addr_r;
      end
      default: rd_hit_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= udis_pkg::RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_data_nxt;
      rresp_r <= rd_hit_nxt ? udis_pkg::RESP_OKAY : udis_pkg::RESP_DECERR;
    end else if (rvalid_r && rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end else if (!rvalid_r) begin
      arready_r <= 1'b1;
    end
  end

  // Start bits self-clear; they only launch a pulse and mark the operation busy.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= udis_pkg::CTL_RESET_VAL;
      chirp_go_r <= 1'b0;
      restore_go_r <= 1'b0;
    end else begin
      chirp_go_r <= wr_low && wr_idx == udis_pkg::CONTROL_IDX && wdata_r[udis_pkg::CTL_CHIRP_GO];
      restore_go_r <= wr_low && wr_idx == udis_pkg::CONTROL_IDX && wdata_r[udis_pkg::CTL_RESTORE_GO];
      if (wr_low && wr_idx == udis_pkg::CONTROL_IDX) begin
        ctrl_r <= wdata_r[udis_pkg::CTL_STORED_W-1:0];
      end
    end
  end

  assign inact_done = hs_mode_r && !bus_activity && inact_cnt_r == udis_pkg::INACT_LAST;

  // inactivity falls back to full speed.
  always_ff @(posedge aclk) begin
    if (!aresetn || !hs_mode_r || bus_activity) begin
      inact_cnt_r <= '0;
    end else if (!inact_done) begin
      inact_cnt_r <= inact_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hs_mode_r <= 1'b0;
      saved_hs_r <= 1'b0;
      fs_term_r <= 1'b0;
      chirp_busy_r <= 1'b0;
      restore_busy_r <= 1'b0;
    end else begin
      if (inact_done) begin
        saved_hs_r <= 1'b1;
        hs_mode_r <= 1'b0;
        fs_term_r <= 1'b1;
      end else if (chirp_end && chirp_busy_r) begin
        hs_mode_r <= chirp_hs;
        fs_term_r <= 1'b0;
      end else if (restore_end && restore_busy_r) begin
        hs_mode_r <= saved_hs_r;
        fs_term_r <= 1'b0;
      end
      chirp_busy_r <= chirp_go_r | (chirp_busy_r & ~chirp_end);
      restore_busy_r <= restore_go_r | (restore_busy_r & ~restore_end);
    end
  end

  assign reset_evt = ctrl_r[udis_pkg::CTL_ACTIVATE] & ~ctrl_r[udis_pkg::CTL_DETECT_DIS] & line_se0_s
                     & ~hs_mode_r & ~bus_event_status_reg[udis_pkg::BEV_SUSPEND];
  assign suspend_evt = suspend_seen & ~ctrl_r[udis_pkg::CTL_DETECT_DIS] & ~reset_evt
                       & ~bus_event_status_reg[udis_pkg::BEV_BUS_RESET];
  assign non_idle_enable = snooze_indicator | (suspend_indicator & ctrl_r[udis_pkg::CTL_AUTO_NEGO]);
  always_comb begin
    bev_set = 8'h00;
    bev_set[udis_pkg::BEV_NON_IDLE] = non_idle_enable & ~line_j_s;
    bev_set[udis_pkg::BEV_FRAME_START] = frame_start_seen;
    bev_set[udis_pkg::BEV_BUS_RESET] = reset_evt;
    bev_set[udis_pkg::BEV_SUSPEND] = suspend_evt;
    bev_set[udis_pkg::BEV_HANDSHAKE] = chirp_end & chirp_busy_r;
    bev_set[udis_pkg::BEV_RESTORE] = restore_end & restore_busy_r;
    bev_set[udis_pkg::BEV_ADDRESS] = setaddr_status_done & ctrl_r[udis_pkg::CTL_AUTO_ADDR];
  end

  always_comb begin
    bulk_set = 8'h00;
    bulk_set[udis_pkg::BULK_CMD_DONE] = cmd_wrapper_rx & ~cmd_wrapper_bad & cmd_wrapper_len == udis_pkg::CMD_WRAPPER_LEN;
    bulk_set[udis_pkg::BULK_CMD_LEN_ERR] = cmd_wrapper_rx & cmd_wrapper_len != udis_pkg::CMD_WRAPPER_LEN;
    bulk_set[udis_pkg::BULK_CMD_ERR] = cmd_wrapper_rx & cmd_wrapper_bad;
    bulk_set[udis_pkg::BULK_STS_DONE] = sts_wrapper_tx & sts_wrapper_len == udis_pkg::STS_WRAPPER_LEN;
    bulk_set[udis_pkg::BULK_STS_ERR] = sts_wrapper_no_ack;
  end

  assign bev_clr = (wr_low && wr_idx == udis_pkg::BUS_EVENT_IDX) ? (wdata_r & bev_rd_mask) : 8'h00;
  assign bulk_clr = (wr_low && wr_idx == udis_pkg::BULK_WRAPPER_IDX) ? wdata_r : 8'h00;

  // A set in the same cycle as its clear wins, so no event is lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_event_status_reg <= udis_pkg::BEV_RESET_VAL;
    end else begin
      bus_event_status_reg <= ((bus_event_status_reg & ~bev_clr) | bev_set) & udis_pkg::BEV_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bulk_wrapper_status_reg <= udis_pkg::BULK_RESET_VAL;
    end else begin
      bulk_wrapper_status_reg <= ((bulk_wrapper_status_reg & ~bulk_clr) | bulk_set) & udis_pkg::BULK_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dev_addr_r <= '0;
    end else if (bev_set[udis_pkg::BEV_ADDRESS]) begin
      dev_addr_r <= setaddr_value;
    end
  end

  for (genvar e = 0; e < udis_pkg::NUM_EP; e++) begin : g_ep
    assign ep_any[e] = |(ep_stat[e*udis_pkg::EP_STAT_W +: udis_pkg::EP_STAT_W]
                         & ep_enb[e*udis_pkg::EP_STAT_W +: udis_pkg::EP_STAT_W]);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      endpoint_summary_status_reg <= udis_pkg::SUM_RESET_VAL;
    end else begin
      endpoint_summary_status_reg <= {|(alarm_in_stat & alarm_in_enb), |(alarm_out_stat & alarm_out_enb),
                                      1'b0, ep_any};
    end
  end

  frame_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    frame_start_seen |=> bus_event_status_reg[udis_pkg::BEV_FRAME_START])
    else $error("Frame-start flag did not set.");
  w1c_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(bulk_wrapper_status_reg[udis_pkg::BULK_CMD_DONE]) |-> $past(bulk_clr[udis_pkg::BULK_CMD_DONE]))
    else $error("Command-wrapper flag fell without a clear.");
  suspend_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_event_status_reg[udis_pkg::BEV_SUSPEND]) |-> !$past(bus_event_status_reg[udis_pkg::BEV_BUS_RESET]))
    else $error("Suspend set while reset pending.");
  reset_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_event_status_reg[udis_pkg::BEV_BUS_RESET]) |-> !$past(bus_event_status_reg[udis_pkg::BEV_SUSPEND]))
    else $error("Reset set while suspend pending.");
  reset_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_event_status_reg[udis_pkg::BEV_BUS_RESET]) |-> $past(ctrl_r[udis_pkg::CTL_ACTIVATE]))
    else $error("Reset detected while inactive.");
  fs_fallback_a: assert property (@(posedge aclk) disable iff (!aresetn)
    inact_done |=> fs_term_r && !hs_mode_r)
    else $error("No full-speed fallback after inactivity.");
  chirp_speed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    chirp_end && chirp_busy_r |=> bus_event_status_reg[udis_pkg::BEV_HANDSHAKE] && hs_mode_r == $past(chirp_hs))
    else $error("Handshake end not reflected.");
  addr_load_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_event_status_reg[udis_pkg::BEV_ADDRESS]) |-> dev_addr_r == $past(setaddr_value))
    else $error("Address not loaded with flag.");
  host_hide_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready_r && rd_idx == udis_pkg::BUS_EVENT_IDX && !dev_mode |=> rdata_r[5:0] == 6'h00)
    else $error("Sync bits visible in host mode.");
  cmd_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_wrapper_rx && cmd_wrapper_len != udis_pkg::CMD_WRAPPER_LEN
      |=> bulk_wrapper_status_reg[udis_pkg::BULK_CMD_LEN_ERR] && !$rose(bulk_wrapper_status_reg[udis_pkg::BULK_CMD_DONE]))
    else $error("Command wrapper length error missed.");
  ep_summary_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 endpoint_summary_status_reg[udis_pkg::NUM_EP-1:0] == $past(ep_any))
    else $error("Endpoint summary mismatch.");
  unmapped_a: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready_r && !rd_hit_nxt |=> rresp_r == udis_pkg::RESP_DECERR && rdata_r == 32'h0000_0000)
    else $error("Unmapped read not refused.");

  reset_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(bus_event_status_reg[udis_pkg::BEV_BUS_RESET]));
  set_clear_c: cover property (@(posedge aclk) disable iff (!aresetn)
    |(bev_set & bev_clr));
  restore_c: cover property (@(posedge aclk) disable iff (!aresetn)
    inact_done ##[1:1000] (restore_end && restore_busy_r));
endmodule

// *** verif/udis_far_model.sv ***
/*
  Serial engine model: pulses one event per call with its payload.
  Assumes the bench calls send from one process at a time.
*/
`timescale 1ns/1ns
module udis_far_model (
  input wire logic aclk,
  output logic [7:0] ev,
  output logic [9:0] len,
  output logic flag
);
  initial begin
    ev = 8'h00;
    len = 10'h3ff;
    flag = 1'b0;
  end
  // Payload is inverted after the pulse so that a stale value is never read as valid.
  task automatic send(input logic [7:0] e, input logic [9:0] l, input logic f);
    @(posedge aclk);
    ev <= e;
    len <= l;
    flag <= f;
    @(posedge aclk);
    ev <= 8'h00;
    len <= ~l;
    flag <= ~f;
  endtask
endmodule

// *** verif/test_usb_device_irq_status.sv ***
/*
  Bench of the interrupt status block: AXI4-Lite master tasks and scenarios.
  Assumes udis_pkg is compiled first.
*/
`timescale 1ns/1ns
module test_usb_device_irq_status;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic line_j_pin, line_se0_pin, snooze_indicator, suspend_indicator, bus_activity, flag;
  logic hs_mode, fs_termination, chirp_go, restore_go;
  logic [6:0] device_address;
  logic [7:0] ev;
  logic [9:0] len;
  logic [39:0] ep_stat, ep_enb;
  logic [15:0] alarm_in_stat, alarm_in_enb, alarm_out_stat, alarm_out_enb;
  int errors = 0;
  int comparisons = 0;
  localparam logic [11:0] BEV = {udis_pkg::BUS_EVENT_IDX, 2'h0};
  localparam logic [11:0] BLK = {udis_pkg::BULK_WRAPPER_IDX, 2'h0};
  localparam logic [11:0] SUM = {udis_pkg::EP_SUMMARY_IDX, 2'h0};
  localparam logic [11:0] CTL = {udis_pkg::CONTROL_IDX, 2'h0};
  localparam logic [1:0] OK = udis_pkg::RESP_OKAY;

  udis_top dut (.*, .frame_start_seen(ev[0]), .suspend_seen(ev[1]), .chirp_end(ev[2]), .chirp_hs(flag),
    .restore_end(ev[3]), .setaddr_status_done(ev[4]), .setaddr_value(len[6:0]), .cmd_wrapper_rx(ev[5]),
    .cmd_wrapper_len(len), .cmd_wrapper_bad(flag), .sts_wrapper_tx(ev[6]), .sts_wrapper_len(len),
    .sts_wrapper_no_ack(ev[7]));
  udis_far_model far (.*);

  always #2 aclk = ~aclk;

  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rchk(input string what, input logic [11:0] a, input logic [7:0] exp, input logic [1:0] rsp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk(what, {24'h0, exp}, rdata);
    chk("rresp", {30'h0, rsp}, {30'h0, rresp});
  endtask

  task automatic t_frame_and_port1();
    rchk("bus event", BEV, 8'h00, OK);
    far.send(8'h01, 10'h000, 1'b0);
    rchk("sof", BEV, 8'h20, OK);
    rchk("port1", BEV | 12'h800, 8'h00, udis_pkg::RESP_DECERR);
    wr(BEV, 8'hdf);
    rchk("zero write", BEV, 8'h20, OK);
    wr(BEV, 8'h20);
    rchk("one write", BEV, 8'h00, OK);
  endtask

  task automatic t_bulk();
    far.send(8'h20, 10'h01f, 1'b0);
    rchk("cmd done", BLK, 8'h80, OK);
    wr(BLK, 8'hff);
    far.send(8'h20, 10'h01e, 1'b0);
    far.send(8'h20, 10'h01f, 1'b1);
    rchk("cmd errors", BLK, 8'h60, OK);
    wr(BLK, 8'hff);
    far.send(8'h40, 10'h00d, 1'b0);
    far.send(8'h40, 10'h00c, 1'b0);
    far.send(8'h80, 10'h00d, 1'b0);
    rchk("sts flags", BLK, 8'h0c, OK);
    wr(BLK, 8'hff);
    rchk("bulk clear", BLK, 8'h00, OK);
  endtask

  task automatic t_summary();
    @(posedge aclk);
    ep_stat <= 40'h10_0000_0001;
    ep_enb <= 40'h01_0000_0003;
    alarm_in_stat <= 16'h8000;
    alarm_in_enb <= 16'h8001;
    alarm_out_stat <= 16'h0001;
    alarm_out_enb <= 16'h0002;
    rchk("summary", SUM, 8'h81, OK);
    wr(SUM, 8'h7e);
    rchk("summary ro", SUM, 8'h81, OK);
  endtask

  task automatic t_host_mode();
    wr(CTL, 8'h01);
    far.send(8'h01, 10'h000, 1'b0);
    rchk("host hides", BEV, 8'h00, OK);
    wr(BEV, 8'hff);
    wr(CTL, 8'h00);
    rchk("device again", BEV, 8'h20, OK);
    wr(BEV, 8'hff);
  endtask

  task automatic t_reset_suspend();
    @(posedge aclk);
    line_se0_pin <= 1'b1;
    idle(6);
    rchk("inactive", BEV, 8'h00, OK);
    far.send(8'h02, 10'h000, 1'b0);
    wr(CTL, 8'h02);
    idle(6);
    rchk("suspend", BEV, 8'h08, OK);
    wr(BEV, 8'h08);
    idle(6);
    rchk("reset", BEV, 8'h10, OK);
    far.send(8'h02, 10'h000, 1'b0);
    rchk("no suspend", BEV, 8'h10, OK);
    wr(CTL, 8'h0a);
    @(posedge aclk);
    line_se0_pin <= 1'b0;
    idle(6);
    wr(BEV, 8'h10);
    wr(CTL, 8'h02);
    rchk("cleared", BEV, 8'h00, OK);
  endtask

  task automatic t_chirp_restore_addr();
    wr(CTL, 8'h22);
    far.send(8'h04, 10'h000, 1'b1);
    rchk("handshake", BEV, 8'h04, OK);
    chk("hs_mode", 32'h1, {31'h0, hs_mode});
    wr(CTL, 8'h42);
    far.send(8'h08, 10'h000, 1'b0);
    rchk("restore", BEV, 8'h06, OK);
    wr(CTL, 8'h12);
    far.send(8'h10, 10'h02a, 1'b0);
    rchk("address", BEV, 8'h07, OK);
    chk("dev addr", 32'h2a, {25'h0, device_address});
  endtask

  task automatic t_non_idle();
    @(posedge aclk);
    snooze_indicator <= 1'b1;
    line_j_pin <= 1'b0;
    idle(6);
    rchk("non idle", BEV, 8'h47, OK);
    @(posedge aclk);
    snooze_indicator <= 1'b0;
    line_j_pin <= 1'b1;
    idle(6);
    wr(BEV, 8'hff);
    rchk("non idle clear", BEV, 8'h00, OK);
  endtask

  task automatic t_fallback();
    wr(CTL, 8'h22);
    chk("chirp_go", 32'h1, {31'h0, chirp_go});
    far.send(8'h04, 10'h000, 1'b1);
    idle(760);
    chk("fs_termination", 32'h1, {31'h0, fs_termination});
    chk("hs after idle", 32'h0, {31'h0, hs_mode});
    wr(CTL, 8'h42);
    chk("restore_go", 32'h1, {31'h0, restore_go});
    far.send(8'h08, 10'h000, 1'b0);
    idle(2);
    chk("hs restored", 32'h1, {31'h0, hs_mode});
    chk("fs term off", 32'h0, {31'h0, fs_termination});
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    tally_and_finish();
  end

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    line_j_pin = 1'b1;
    wstrb = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready, line_se0_pin, snooze_indicator, suspend_indicator} = '0;
    {bus_activity, awaddr, araddr, wdata, ep_stat, ep_enb} = '0;
    {alarm_in_stat, alarm_in_enb, alarm_out_stat, alarm_out_enb} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    t_frame_and_port1();
    t_bulk();
    t_summary();
    t_host_mode();
    t_reset_suspend();
    t_chirp_restore_addr();
    t_non_idle();
    t_fallback();
    tally_and_finish();
  end
endmodule
